// ==== pio_pkg.sv ====
// packed io status words: register map, field layout and encodings
// assumes a 32-bit axi4-lite slave with 16-bit byte addresses
package pio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_FRONT_INPUT_LEVELS    = 12'h83B;
  localparam logic [11:0] IDX_TERMINAL_INPUT_LEVELS = 12'h83C;
  localparam logic [11:0] IDX_FRONT_OUTPUT_DRIVE    = 12'h83D;
  localparam logic [11:0] IDX_TERMINAL_OUTPUT_DRIVE = 12'h83E;
  localparam logic [11:0] IDX_FRONT_FAULT_FLAGS     = 12'h83F;
  localparam logic [11:0] IDX_TERMINAL_LV_FAULT     = 12'h840;
  localparam logic [11:0] IDX_FRONT_OUTPUT_SOURCE   = 12'h841;
  localparam logic [11:0] IDX_TERMINAL_OUTPUT_SOURCE = 12'h842;
  localparam logic [11:0] IDX_IRQ_STATUS            = 12'h843;
  localparam logic [11:0] IDX_IRQ_MASK              = 12'h844;

  ////////////////////////////////////////////////////////////////////////////
  // field widths and positions
  localparam int unsigned FRONT_IN_W     = 8;
  localparam int unsigned TERM_IN_W      = 28;
  localparam int unsigned TERM_24V_W     = 16;
  localparam int unsigned TERM_5V_LSB    = 16;
  localparam int unsigned FRONT_OUT_W    = 2;
  localparam int unsigned TERM_OUT_W     = 12;
  localparam int unsigned FRONT_OPEN_W   = 2;
  localparam int unsigned TERM_OPEN_W    = 12;
  localparam int unsigned TERM_OPEN_LSB  = 16;
  localparam int unsigned FAULT_SUM_BIT  = 31;
  localparam int unsigned SYNC_W         = FRONT_IN_W + TERM_IN_W + 1 + FRONT_OPEN_W + 1
                                           + TERM_OPEN_W;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask layout
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_FRONT_FLT  = 0;
  localparam int unsigned IRQ_TERM_FLT   = 1;
  localparam int unsigned IRQ_FRONT_IN   = 2;
  localparam int unsigned IRQ_TERM_IN    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [FRONT_OUT_W-1:0] FRONT_OUT_RST = 2'h0;
  localparam logic [TERM_OUT_W-1:0]  TERM_OUT_RST  = 12'h000;
  localparam logic [IRQ_W-1:0]       IRQ_MASK_RST  = 4'h0;
  localparam logic [DATA_W-1:0]      RDATA_RST     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // responses and channel states
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WR_IDLE   = 3'b001,
    WR_ACCEPT = 3'b010,
    WR_RESP   = 3'b100
  } pio_wr_state_t;

  typedef enum logic [2:0] {
    RD_IDLE   = 3'b001,
    RD_ACCEPT = 3'b010,
    RD_DATA   = 3'b100
  } pio_rd_state_t;

endpackage : pio_pkg

// ==== pio_sync.sv ====
// three-flop input synchroniser with agreement filter
// assumes din is asynchronous to aclk
`timescale 1ns/10ps
module pio_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  ////////////////////////////////////////////////////////////////////////////
  // s1 feeds s2 only; a bit counts once s2 and s3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
    end
  end

  assign dout = out_q;

endmodule : pio_sync

// ==== pio_top.sv ====
// packed io status words behind an axi4-lite slave
// assumes field pins are asynchronous and cam-switch drives are on aclk
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps

module pio_top (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [pio_pkg::ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic [2:0]                           s_axi_awprot,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [pio_pkg::DATA_W-1:0]           s_axi_wdata,
  input  wire logic [pio_pkg::STRB_W-1:0]           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [pio_pkg::ADDR_W-1:0]           s_axi_araddr,
  input  wire logic [2:0]                           s_axi_arprot,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [pio_pkg::DATA_W-1:0]                s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  input  wire logic [pio_pkg::FRONT_IN_W-1:0]       front_panel_points_in,
  input  wire logic [pio_pkg::TERM_IN_W-1:0]        remote_fiber_terminal_in,
  input  wire logic                                 front_panel_points_overcurrent,
  input  wire logic [pio_pkg::FRONT_OPEN_W-1:0]     front_panel_points_open_wire,
  input  wire logic                                 remote_fiber_terminal_enc_power_fault,
  input  wire logic [pio_pkg::TERM_OPEN_W-1:0]      remote_fiber_terminal_open_wire,
  input  wire logic [pio_pkg::FRONT_OUT_W-1:0]      front_panel_points_cam,
  input  wire logic [pio_pkg::TERM_OUT_W-1:0]       remote_fiber_terminal_cam,
  output logic [pio_pkg::FRONT_OUT_W-1:0]           front_panel_points_out,
  output logic [pio_pkg::TERM_OUT_W-1:0]            remote_fiber_terminal_out,
  output logic                                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_hit(input logic [pio_pkg::ADDR_W-1:0] addr,
                                    input logic [11:0]                idx);
    addr_hit = (addr[pio_pkg::ADDR_W-1:2] == {2'b00, idx});
  endfunction : addr_hit

  // byte-lane merge, then keep only the implemented bits
  function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb,
                                           input logic [31:0] keep);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    wr_merge = m & keep;
  endfunction : wr_merge

  ////////////////////////////////////////////////////////////////////////////
  // field inputs through the synchroniser

  logic [pio_pkg::SYNC_W-1:0]       raw_bus;
  logic [pio_pkg::SYNC_W-1:0]       sync_bus;
  logic [pio_pkg::FRONT_IN_W-1:0]   fp_in_s;
  logic [pio_pkg::TERM_IN_W-1:0]    term_in_s;
  logic                             fp_oc_s;
  logic [pio_pkg::FRONT_OPEN_W-1:0] fp_ow_s;
  logic                             term_enc_s;
  logic [pio_pkg::TERM_OPEN_W-1:0]  term_ow_s;

  assign raw_bus = {front_panel_points_in, remote_fiber_terminal_in,
                    front_panel_points_overcurrent, front_panel_points_open_wire,
                    remote_fiber_terminal_enc_power_fault, remote_fiber_terminal_open_wire};

  pio_sync #(
    .WIDTH (pio_pkg::SYNC_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (raw_bus),
    .dout    (sync_bus)
  );

  assign {fp_in_s, term_in_s, fp_oc_s, fp_ow_s, term_enc_s, term_ow_s} = sync_bus;

  ////////////////////////////////////////////////////////////////////////////
  // state

  pio_pkg::pio_wr_state_t            wr_state_q;
  pio_pkg::pio_wr_state_t            wr_state_d;
  pio_pkg::pio_rd_state_t            rd_state_q;
  pio_pkg::pio_rd_state_t            rd_state_d;
  logic [1:0]                        bresp_q;
  logic [31:0]                       rdata_q;
  logic [1:0]                        rresp_q;
  logic [pio_pkg::FRONT_OUT_W-1:0]   fp_drive_q;
  logic [pio_pkg::TERM_OUT_W-1:0]    term_drive_q;
  logic [pio_pkg::FRONT_OUT_W-1:0]   fp_src_q;
  logic [pio_pkg::TERM_OUT_W-1:0]    term_src_q;
  logic [pio_pkg::FRONT_OUT_W-1:0]   fp_out_q;
  logic [pio_pkg::TERM_OUT_W-1:0]    term_out_q;
  logic [pio_pkg::IRQ_W-1:0]         irq_stat_q;
  logic [pio_pkg::IRQ_W-1:0]         irq_stat_d;
  logic [pio_pkg::IRQ_W-1:0]         irq_mask_q;
  logic                              irq_q;
  logic [31:0]                       fp_flt_prev_q;
  logic [31:0]                       term_flt_prev_q;
  logic [pio_pkg::FRONT_IN_W-1:0]    fp_in_prev_q;
  logic [pio_pkg::TERM_IN_W-1:0]     term_in_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // word assembly

  logic [31:0] front_in_word;
  logic [31:0] term_in_word;
  logic [31:0] front_out_word;
  logic [31:0] term_out_word;
  logic [31:0] front_flt_word;
  logic [31:0] term_flt_word;
  logic [31:0] front_src_word;
  logic [31:0] term_src_word;
  logic [31:0] irq_stat_word;
  logic [31:0] irq_mask_word;

  assign front_in_word  = {{(32-pio_pkg::FRONT_IN_W){1'b0}}, fp_in_s};
  assign term_in_word   = {{(32-pio_pkg::TERM_IN_W){1'b0}}, term_in_s};
  assign front_out_word = {{(32-pio_pkg::FRONT_OUT_W){1'b0}}, fp_drive_q};
  assign term_out_word  = {{(32-pio_pkg::TERM_OUT_W){1'b0}}, term_drive_q};
  assign front_flt_word = {fp_oc_s, {(31-pio_pkg::FRONT_OPEN_W){1'b0}}, fp_ow_s};
  assign term_flt_word  = {term_enc_s,
                           {(pio_pkg::FAULT_SUM_BIT-pio_pkg::TERM_OPEN_LSB
                             -pio_pkg::TERM_OPEN_W){1'b0}},
                           term_ow_s,
                           {pio_pkg::TERM_OPEN_LSB{1'b0}}};
  assign front_src_word = {{(32-pio_pkg::FRONT_OUT_W){1'b0}}, fp_src_q};
  assign term_src_word  = {{(32-pio_pkg::TERM_OUT_W){1'b0}}, term_src_q};
  assign irq_stat_word  = {{(32-pio_pkg::IRQ_W){1'b0}}, irq_stat_q};
  assign irq_mask_word  = {{(32-pio_pkg::IRQ_W){1'b0}}, irq_mask_q};

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  logic wr_fire;
  logic wr_front_out;
  logic wr_term_out;
  logic wr_front_src;
  logic wr_term_src;
  logic wr_mask;
  logic wr_mapped;

  assign wr_fire      = (wr_state_q == pio_pkg::WR_ACCEPT) & s_axi_awvalid & s_axi_wvalid;
  assign wr_front_out = addr_hit(s_axi_awaddr, pio_pkg::IDX_FRONT_OUTPUT_DRIVE);
  assign wr_term_out  = addr_hit(s_axi_awaddr, pio_pkg::IDX_TERMINAL_OUTPUT_DRIVE);
  assign wr_front_src = addr_hit(s_axi_awaddr, pio_pkg::IDX_FRONT_OUTPUT_SOURCE);
  assign wr_term_src  = addr_hit(s_axi_awaddr, pio_pkg::IDX_TERMINAL_OUTPUT_SOURCE);
  assign wr_mask      = addr_hit(s_axi_awaddr, pio_pkg::IDX_IRQ_MASK);
  assign wr_mapped    = wr_front_out | wr_term_out | wr_front_src | wr_term_src | wr_mask
                        | addr_hit(s_axi_awaddr, pio_pkg::IDX_FRONT_INPUT_LEVELS)
                        | addr_hit(s_axi_awaddr, pio_pkg::IDX_TERMINAL_INPUT_LEVELS)
                        | addr_hit(s_axi_awaddr, pio_pkg::IDX_FRONT_FAULT_FLAGS)
                        | addr_hit(s_axi_awaddr, pio_pkg::IDX_TERMINAL_LV_FAULT)
                        | addr_hit(s_axi_awaddr, pio_pkg::IDX_IRQ_STATUS);

  always_comb begin
    case (wr_state_q)
      pio_pkg::WR_IDLE:   wr_state_d = (s_axi_awvalid & s_axi_wvalid) ? pio_pkg::WR_ACCEPT
                                                                      : pio_pkg::WR_IDLE;
      pio_pkg::WR_ACCEPT: wr_state_d = wr_fire ? pio_pkg::WR_RESP : pio_pkg::WR_ACCEPT;
      pio_pkg::WR_RESP:   wr_state_d = s_axi_bready ? pio_pkg::WR_IDLE : pio_pkg::WR_RESP;
      default:            wr_state_d = pio_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= pio_pkg::WR_IDLE;
      bresp_q    <= pio_pkg::RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      if (wr_fire) begin
        // read-only words accept the write silently; unmapped words get slverr
        bresp_q <= wr_mapped ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
      end
    end
  end

  // reserved bits are masked off on every write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_drive_q   <= pio_pkg::FRONT_OUT_RST;
      term_drive_q <= pio_pkg::TERM_OUT_RST;
      fp_src_q     <= pio_pkg::FRONT_OUT_RST;
      term_src_q   <= pio_pkg::TERM_OUT_RST;
      irq_mask_q   <= pio_pkg::IRQ_MASK_RST;
    end else if (wr_fire) begin
      if (wr_front_out) begin
        fp_drive_q <= pio_pkg::FRONT_OUT_W'(wr_merge(front_out_word, s_axi_wdata,
                                                      s_axi_wstrb, 32'h0000_0003));
      end
      if (wr_term_out) begin
        term_drive_q <= pio_pkg::TERM_OUT_W'(wr_merge(term_out_word, s_axi_wdata,
                                                       s_axi_wstrb, 32'h0000_0FFF));
      end
      if (wr_front_src) begin
        fp_src_q <= pio_pkg::FRONT_OUT_W'(wr_merge(front_src_word, s_axi_wdata,
                                                    s_axi_wstrb, 32'h0000_0003));
      end
      if (wr_term_src) begin
        term_src_q <= pio_pkg::TERM_OUT_W'(wr_merge(term_src_word, s_axi_wdata,
                                                     s_axi_wstrb, 32'h0000_0FFF));
      end
      if (wr_mask) begin
        irq_mask_q <= pio_pkg::IRQ_W'(wr_merge(irq_mask_word, s_axi_wdata,
                                                s_axi_wstrb, 32'h0000_000F));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic        rd_fire;
  logic        rd_stat;
  logic        rd_mapped;
  logic [31:0] rd_word;

  assign rd_fire = (rd_state_q == pio_pkg::RD_ACCEPT) & s_axi_arvalid;
  assign rd_stat = addr_hit(s_axi_araddr, pio_pkg::IDX_IRQ_STATUS);
  assign rd_word =
    addr_hit(s_axi_araddr, pio_pkg::IDX_FRONT_INPUT_LEVELS)     ? front_in_word  :
    addr_hit(s_axi_araddr, pio_pkg::IDX_TERMINAL_INPUT_LEVELS)  ? term_in_word   :
    addr_hit(s_axi_araddr, pio_pkg::IDX_FRONT_OUTPUT_DRIVE)     ? front_out_word :
    addr_hit(s_axi_araddr, pio_pkg::IDX_TERMINAL_OUTPUT_DRIVE)  ? term_out_word  :
    addr_hit(s_axi_araddr, pio_pkg::IDX_FRONT_FAULT_FLAGS)      ? front_flt_word :
    addr_hit(s_axi_araddr, pio_pkg::IDX_TERMINAL_LV_FAULT)      ? term_flt_word  :
    addr_hit(s_axi_araddr, pio_pkg::IDX_FRONT_OUTPUT_SOURCE)    ? front_src_word :
    addr_hit(s_axi_araddr, pio_pkg::IDX_TERMINAL_OUTPUT_SOURCE) ? term_src_word  :
    rd_stat                                                     ? irq_stat_word  :
    addr_hit(s_axi_araddr, pio_pkg::IDX_IRQ_MASK)               ? irq_mask_word  :
    pio_pkg::RDATA_RST;
  assign rd_mapped = (rd_word != pio_pkg::RDATA_RST) | rd_stat
                     | ((s_axi_araddr[pio_pkg::ADDR_W-1:2]
                         >= {2'b00, pio_pkg::IDX_FRONT_INPUT_LEVELS})
                        && (s_axi_araddr[pio_pkg::ADDR_W-1:2] <= {2'b00, pio_pkg::IDX_IRQ_MASK}));

  always_comb begin
    case (rd_state_q)
      pio_pkg::RD_IDLE:   rd_state_d = s_axi_arvalid ? pio_pkg::RD_ACCEPT : pio_pkg::RD_IDLE;
      pio_pkg::RD_ACCEPT: rd_state_d = rd_fire ? pio_pkg::RD_DATA : pio_pkg::RD_ACCEPT;
      pio_pkg::RD_DATA:   rd_state_d = s_axi_rready ? pio_pkg::RD_IDLE : pio_pkg::RD_DATA;
      default:            rd_state_d = pio_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= pio_pkg::RD_IDLE;
      rdata_q    <= pio_pkg::RDATA_RST;
      rresp_q    <= pio_pkg::RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      if (rd_fire) begin
        rdata_q <= rd_word;
        rresp_q <= rd_mapped ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: new fault bits and input changes

  logic [pio_pkg::IRQ_W-1:0] irq_set;
  logic [pio_pkg::IRQ_W-1:0] irq_clr;

  assign irq_set[pio_pkg::IRQ_FRONT_FLT] = |(front_flt_word & ~fp_flt_prev_q);
  assign irq_set[pio_pkg::IRQ_TERM_FLT]  = |(term_flt_word & ~term_flt_prev_q);
  assign irq_set[pio_pkg::IRQ_FRONT_IN]  = |(fp_in_s ^ fp_in_prev_q);
  assign irq_set[pio_pkg::IRQ_TERM_IN]   = |(term_in_s ^ term_in_prev_q);
  assign irq_clr    = {pio_pkg::IRQ_W{rd_fire & rd_stat}};
  // set wins over the read clear
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q      <= '0;
      irq_q           <= 1'b0;
      fp_flt_prev_q   <= '0;
      term_flt_prev_q <= '0;
      fp_in_prev_q    <= '0;
      term_in_prev_q  <= '0;
    end else begin
      irq_stat_q      <= irq_stat_d;
      irq_q           <= |(irq_stat_d & irq_mask_q);
      fp_flt_prev_q   <= front_flt_word;
      term_flt_prev_q <= term_flt_word;
      fp_in_prev_q    <= fp_in_s;
      term_in_prev_q  <= term_in_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drivers: source-select picks cam switch or written value

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_out_q   <= pio_pkg::FRONT_OUT_RST;
      term_out_q <= pio_pkg::TERM_OUT_RST;
    end else begin
      fp_out_q   <= (fp_src_q & front_panel_points_cam) | (~fp_src_q & fp_drive_q);
      term_out_q <= (term_src_q & remote_fiber_terminal_cam)
                    | (~term_src_q & term_drive_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drive

  assign s_axi_awready             = wr_state_q[1];
  assign s_axi_wready              = wr_state_q[1];
  assign s_axi_bvalid              = wr_state_q[2];
  assign s_axi_bresp               = bresp_q;
  assign s_axi_arready             = rd_state_q[1];
  assign s_axi_rvalid              = rd_state_q[2];
  assign s_axi_rdata               = rdata_q;
  assign s_axi_rresp               = rresp_q;
  assign front_panel_points_out    = fp_out_q;
  assign remote_fiber_terminal_out = term_out_q;
  assign irq                       = irq_q;

endmodule : pio_top

// ==== pio_checker.sv ====
// checker for the packed io status words: bus handshakes and reserved read bits
// assumes it is bound to pio_top and sees only its ports
`timescale 1ns/10ps
module pio_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq
);
  logic [11:0] rd_idx_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_idx_q <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) rd_idx_q <= s_axi_araddr[13:2];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_w_paired: assert property (s_axi_awready == s_axi_wready)
    else $error("aw and w ready split");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no rvalid");
  a_front_in_rsv: assert property (s_axi_rvalid && rd_idx_q == 12'h83B
    |-> s_axi_rdata[31:8] == 24'h0) else $error("front input reserved bits set");
  a_term_in_rsv: assert property (s_axi_rvalid && rd_idx_q == 12'h83C
    |-> s_axi_rdata[31:28] == 4'h0) else $error("terminal input reserved bits set");
  a_front_out_rsv: assert property (s_axi_rvalid && rd_idx_q == 12'h83D
    |-> s_axi_rdata[31:2] == 30'h0) else $error("front output reserved bits set");
  a_term_out_rsv: assert property (s_axi_rvalid && rd_idx_q == 12'h83E
    |-> s_axi_rdata[31:12] == 20'h0) else $error("terminal output reserved bits set");
  a_front_flt_rsv: assert property (s_axi_rvalid && rd_idx_q == 12'h83F
    |-> s_axi_rdata[30:2] == 29'h0) else $error("front fault reserved bits set");
  a_term_flt_rsv: assert property (s_axi_rvalid && rd_idx_q == 12'h840
    |-> s_axi_rdata[30:28] == 3'h0 && s_axi_rdata[15:0] == 16'h0)
    else $error("terminal fault reserved set");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule : pio_checker
bind pio_top pio_checker pio_checker_i (.*);

// ==== pio_field_model.sv ====
// field side model: front panel and remote terminal points, levels and faults
// assumes the bench sets the field scene on the clock edge
`timescale 1ns/10ps
module pio_field_model (
  input  wire logic [7:0]  fi,
  input  wire logic [27:0] ti,
  input  wire logic [13:0] ow,
  input  wire logic [1:0]  pf,
  output logic      [7:0]  front_panel_points_in,
  output logic      [27:0] remote_fiber_terminal_in,
  output logic      [1:0]  front_panel_points_open_wire,
  output logic      [11:0] remote_fiber_terminal_open_wire,
  output logic             front_panel_points_overcurrent,
  output logic             remote_fiber_terminal_enc_power_fault
);
  assign front_panel_points_in = fi;
  assign remote_fiber_terminal_in = ti;
  assign front_panel_points_open_wire = ow[1:0];
  assign remote_fiber_terminal_open_wire = ow[13:2];
  assign front_panel_points_overcurrent = pf[0];
  assign remote_fiber_terminal_enc_power_fault = pf[1];
endmodule : pio_field_model

// ==== tb_top.sv ====
// self-checking bench for the packed io status words
// assumes pio_top with its bound checker and the field model
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [11:0] idx; logic wr; logic [31:0] wd; logic [7:0] fi; logic [27:0] ti;
    logic [13:0] ow; logic [1:0] pf; logic [31:0] ex;} pio_row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0, rd, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, front_panel_points_open_wire, front_panel_points_out;
  logic [1:0] pf = 2'h0, front_panel_points_cam = 2'h0;
  logic [7:0] fi = 8'h00, front_panel_points_in;
  logic [27:0] ti = 28'h0, remote_fiber_terminal_in;
  logic [13:0] ow = 14'h0;
  logic [11:0] remote_fiber_terminal_cam = 12'h000, remote_fiber_terminal_open_wire;
  logic [11:0] remote_fiber_terminal_out;
  logic front_panel_points_overcurrent, remote_fiber_terminal_enc_power_fault;
  int mismatches = 0, n_compared = 0, cyc = 0;
  pio_row_t rows [6] = '{'{12'h83B, 0, 32'h0, 8'hA5, 28'h0, 14'h0, 2'h0, 32'h0000_00A5},
    '{12'h83C, 0, 32'h0, 8'h00, 28'hABCDE12, 14'h0, 2'h0, 32'h0ABC_DE12},
    '{12'h83D, 1, 32'hFFFF_FFFF, 8'h00, 28'h0, 14'h0, 2'h0, 32'h0000_0003},
    '{12'h83E, 1, 32'hFFFF_FFFF, 8'h00, 28'h0, 14'h0, 2'h0, 32'h0000_0FFF},
    '{12'h83F, 0, 32'h0, 8'h00, 28'h0, 14'h0002, 2'h1, 32'h8000_0002},
    '{12'h840, 0, 32'h0, 8'h3C, 28'h0, 14'h2004, 2'h2, 32'h8801_0000}};
  pio_top pio_top_i (.*);
  pio_field_model pio_field_model_i (.*);
  always #2 aclk = ~aclk;
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic a, w;
    a = 0;
    w = 0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      a = a | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= ~a;
      s_axi_wvalid <= ~w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdw(input logic [11:0] idx);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdw
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      {fi, ti, ow, pf} <= {rows[i].fi, rows[i].ti, rows[i].ow, rows[i].pf};
      if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
      repeat (8) @(posedge aclk);
      rdw(rows[i].idx);
      chk("word", rd, rows[i].ex);
      $display("row %0d done", i);
    end
    wr(pio_pkg::IDX_FRONT_OUTPUT_DRIVE, 32'h1);
    wr(pio_pkg::IDX_TERMINAL_OUTPUT_DRIVE, 32'h0000_0A5C);
    repeat (3) @(posedge aclk);
    chk("front out", {30'h0, front_panel_points_out}, 32'h1);
    chk("term out", {20'h0, remote_fiber_terminal_out}, 32'hA5C);
    front_panel_points_cam <= 2'h2;
    remote_fiber_terminal_cam <= 12'hFF0;
    wr(pio_pkg::IDX_FRONT_OUTPUT_SOURCE, 32'h3);
    wr(pio_pkg::IDX_TERMINAL_OUTPUT_SOURCE, 32'h00F);
    wr(pio_pkg::IDX_FRONT_OUTPUT_DRIVE, 32'h1);
    repeat (3) @(posedge aclk);
    chk("cam front", {30'h0, front_panel_points_out}, 32'h2);
    chk("cam term", {20'h0, remote_fiber_terminal_out}, 32'hA50);
    s_axi_wstrb <= 4'hE;
    wr(pio_pkg::IDX_FRONT_OUTPUT_DRIVE, 32'h0);
    s_axi_wstrb <= 4'hF;
    rdw(pio_pkg::IDX_FRONT_OUTPUT_DRIVE);
    chk("strobe lane", rd, 32'h1);
    $display("source select done");
    wr(12'h850, 32'h1);
    chk("unmapped wr", {30'h0, rs}, 32'h2);
    rdw(12'h850);
    chk("unmapped rd", rd, 32'h0);
    chk("unmapped rresp", {30'h0, rs}, 32'h2);
    wr(pio_pkg::IDX_FRONT_INPUT_LEVELS, 32'hFFFF_FFFF);
    rdw(pio_pkg::IDX_FRONT_INPUT_LEVELS);
    chk("ro write", rd, {24'h0, fi});
    $display("refusals done");
    wr(pio_pkg::IDX_IRQ_MASK, 32'h4);
    rdw(pio_pkg::IDX_IRQ_STATUS);
    fi <= ~fi;
    repeat (8) @(posedge aclk);
    chk("irq up", {31'h0, irq}, 32'h1);
    rdw(pio_pkg::IDX_IRQ_STATUS);
    chk("status", rd, 32'h4);
    repeat (3) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(pio_pkg::IDX_IRQ_MASK, 32'h0);
    fi <= ~fi;
    repeat (8) @(posedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    $display("interrupt done");
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("reset out", {18'h0, front_panel_points_out, remote_fiber_terminal_out}, 32'h0);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdw(pio_pkg::IDX_TERMINAL_OUTPUT_DRIVE);
    chk("reset drive", rd, 32'h0);
    $display("reset done");
    close_out();
  end
endmodule : tb_top
